// ---- rtl/lbc_consts.vh ----
`ifndef LBC_CONSTS_VH
`define LBC_CONSTS_VH

// Clock period of ref_clk in ns
`define LBC_CLK_NS 10

// Transmit symbol word layout
`define LBC_SYM_W 3
`define LBC_SYM_ACT 0
`define LBC_SYM_DBL 1
`define LBC_SYM_LAST 2

// Times in ns, as printed
`define LBC_T_HALF_MIN_NS 365000
`define LBC_T_DBL_MIN_NS 762000
`define LBC_T_DBL_MAX_NS 905000
`define LBC_T_DESTROY_NS 943300
`define LBC_T_STOP_NS 2450000
`define LBC_T_BREAK_NS 1200000
`define LBC_T_BRK_LAT_NS 450000
`define LBC_T_PRIO1_NS 13500000
`define LBC_T_REC_NS 4000000
`define LBC_T_HALF_BIT_NS 416700

// Least times round up to whole cycles
`define LBC_CEIL(t) (((t) + `LBC_CLK_NS - 1) / `LBC_CLK_NS)

// Cycle counts derived from the times
`define LBC_CYC_HALF_MIN `LBC_CEIL(`LBC_T_HALF_MIN_NS)
`define LBC_CYC_DBL_MIN `LBC_CEIL(`LBC_T_DBL_MIN_NS)
`define LBC_CYC_DBL_MAX `LBC_CEIL(`LBC_T_DBL_MAX_NS)
`define LBC_CYC_DESTROY `LBC_CEIL(`LBC_T_DESTROY_NS)
`define LBC_CYC_STOP `LBC_CEIL(`LBC_T_STOP_NS)
`define LBC_CYC_BREAK `LBC_CEIL(`LBC_T_BREAK_NS)
`define LBC_CYC_PRIO1 `LBC_CEIL(`LBC_T_PRIO1_NS)
`define LBC_CYC_REC `LBC_CEIL(`LBC_T_REC_NS)
`define LBC_CYC_HALF_BIT `LBC_CEIL(`LBC_T_HALF_BIT_NS)

// Counter widths
`define LBC_CNT_W 21
`define LBC_CNT_MAX 21'h1FFFFF

`endif

// ---- rtl/lbc_collision.v ----
`timescale 1ns/1ps
`include "lbc_consts.vh"

module lbc_fifo #(
  parameter DW = 3,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk, // Clock
  input wire rst_n, // Synchronous reset, active low
  input wire ce, // Clock enable
  input wire in_valid, // Write request
  output reg in_ready_q, // Not full
  input wire [DW-1:0] in_data, // Write data
  output wire out_valid, // Not empty
  input wire out_ready, // Read request
  output wire [DW-1:0] out_data // Head word
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  wire push;
  wire pop;

  assign push = in_valid && in_ready_q;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];

  // Occupancy after this cycle
  always @*
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  // Pointers, count and registered full flag
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem[wp_q] <= in_data;
        wp_q <= (wp_q == DEPTH - 1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop)
        rp_q <= (rp_q == DEPTH - 1) ? {AW{1'b0}} : rp_q + 1'b1;
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != DEPTH);
    end
  end
endmodule

module lbc_collision #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2,
  parameter FRM_MAX = 64,
  parameter FRM_AW = 6,
  parameter HALF_MIN = `LBC_CYC_HALF_MIN,
  parameter DBL_MIN = `LBC_CYC_DBL_MIN,
  parameter DBL_MAX = `LBC_CYC_DBL_MAX,
  parameter DESTROY = `LBC_CYC_DESTROY,
  parameter STOP = `LBC_CYC_STOP,
  parameter BREAK = `LBC_CYC_BREAK,
  parameter PRIO = `LBC_CYC_PRIO1,
  parameter REC = `LBC_CYC_REC,
  parameter HALF_BIT = `LBC_CYC_HALF_BIT
) (
  input wire ref_clk, // System clock, 100 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire mm_en, // Multi-master transmitter mode
  input wire sym_valid, // Transmit symbol offered
  output wire sym_ready_q, // Symbol FIFO can take a word
  input wire [`LBC_SYM_W-1:0] sym_data, // {last, double, active}
  input wire bus_in, // Bus level, high is idle
  output reg bus_out_q, // Pin output value, always low
  output reg bus_oe_q, // Pin output enable, pulls bus active
  output reg busy_q, // Frame held and not yet sent
  output reg tx_done_q, // One-cycle pulse, frame sent whole
  output reg coll_q, // Collision seen since last send start
  output reg coll_destroy_q // That collision involved a destroy area
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LOAD = 5'h02;
  localparam [4:0] ST_WAIT = 5'h04;
  localparam [4:0] ST_SEND = 5'h08;
  localparam [4:0] ST_BREAK = 5'h10;

  reg [`LBC_SYM_W-1:0] frm [0:FRM_MAX-1];
  reg [4:0] st_q;
  reg bus_s_q;
  reg first_q;
  reg rec_q;
  reg [`LBC_CNT_W-1:0] width_q;
  reg [`LBC_CNT_W-1:0] tmr_q;
  reg [FRM_AW-1:0] idx_q;
  reg [FRM_AW-1:0] len_q;
  wire f_valid;
  wire f_ready;
  wire [`LBC_SYM_W-1:0] f_data;
  wire edge_w;
  wire bus_act;
  wire w_destroy;
  wire mismatch;
  wire hold_destroy;
  wire det_on;
  wire coll_any;
  wire coll_dst;
  wire [`LBC_SYM_W-1:0] cur;
  wire [`LBC_SYM_W-1:0] nxt;
  wire sym_end;
  wire wait_done;

  // Symbol FIFO between the source and the frame store
  lbc_fifo #(
    .DW(`LBC_SYM_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(sym_valid),
    .in_ready_q(sym_ready_q),
    .in_data(sym_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Store drains only while loading, so the FIFO back-pressures the source
  assign f_ready = (st_q == ST_LOAD);

  // Bus edges and level, low on the wire is the active state
  assign bus_act = !bus_in;
  assign edge_w = bus_in ^ bus_s_q;

  // Width class: half 365-762us, double 762-905us, all else destroy
  // The period is one more than the count seen at the closing edge
  assign w_destroy = (width_q < HALF_MIN - 1) ||
    (width_q >= DBL_MAX - 1);
  assign mismatch = (bus_oe_q != bus_act);

  // Active held too long without an edge
  assign hold_destroy = bus_act && !edge_w && (width_q >= DESTROY - 1);

  // Detection window: multi-master mode and a forward frame going out
  assign det_on = mm_en && (st_q == ST_SEND);
  assign coll_dst = det_on && ((edge_w && !first_q && w_destroy)
    || hold_destroy);
  assign coll_any = coll_dst || (det_on && edge_w && mismatch);

  // Current and following symbol of the stored frame
  assign cur = frm[idx_q];
  assign nxt = frm[idx_q + 1'b1];
  assign sym_end = cur[`LBC_SYM_DBL] ?
    (tmr_q >= 2 * HALF_BIT - 1) : (tmr_q >= HALF_BIT - 1);

  // Idle long enough: recovery time, or stop condition plus settling
  assign wait_done = !bus_act && !edge_w &&
    (rec_q ? (width_q >= REC) : (width_q >= STOP + PRIO));

  // Bus sampler and edge-to-edge width counter
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bus_s_q <= 1'b1;
      width_q <= {`LBC_CNT_W{1'b0}};
    end
    else if (ce)
    begin
      bus_s_q <= bus_in;
      if (edge_w)
        width_q <= {`LBC_CNT_W{1'b0}};
      else if (width_q != `LBC_CNT_MAX)
        width_q <= width_q + 1'b1;
    end
  end

  // Frame store written while loading from the FIFO
  always @(posedge ref_clk)
  begin
    if (ce && f_valid && st_q == ST_LOAD)
      frm[idx_q] <= f_data;
  end

  // Sequencer: load, wait, send, break and recovery
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      idx_q <= {FRM_AW{1'b0}};
      len_q <= {FRM_AW{1'b0}};
      tmr_q <= {`LBC_CNT_W{1'b0}};
      first_q <= 1'b0;
      rec_q <= 1'b0;
      bus_out_q <= 1'b0;
      bus_oe_q <= 1'b0;
      busy_q <= 1'b0;
      tx_done_q <= 1'b0;
      coll_q <= 1'b0;
      coll_destroy_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_done_q <= 1'b0;
      bus_out_q <= 1'b0;
      if (edge_w)
        first_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          idx_q <= {FRM_AW{1'b0}};
          if (f_valid && mm_en)
          begin
            busy_q <= 1'b1;
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          if (f_valid)
          begin
            if (f_data[`LBC_SYM_LAST] || idx_q == FRM_MAX - 1)
            begin
              len_q <= idx_q;
              rec_q <= 1'b0;
              st_q <= ST_WAIT;
            end
            else
              idx_q <= idx_q + 1'b1;
          end
        end
        ST_WAIT:
        begin
          // Always restart from the first symbol
          idx_q <= {FRM_AW{1'b0}};
          tmr_q <= {`LBC_CNT_W{1'b0}};
          if (wait_done && mm_en)
          begin
            bus_oe_q <= frm[0][`LBC_SYM_ACT];
            first_q <= 1'b1;
            coll_q <= 1'b0;
            coll_destroy_q <= 1'b0;
            st_q <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (coll_any)
          begin
            // Release at once, or start the break on a destroy area; keep the frame to resend
            bus_oe_q <= coll_dst;
            coll_q <= 1'b1;
            coll_destroy_q <= coll_dst;
            tmr_q <= {`LBC_CNT_W{1'b0}};
            rec_q <= 1'b0;
            st_q <= coll_dst ? ST_BREAK : ST_WAIT;
          end
          else if (sym_end)
          begin
            tmr_q <= {`LBC_CNT_W{1'b0}};
            if (idx_q == len_q)
            begin
              bus_oe_q <= 1'b0;
              busy_q <= 1'b0;
              tx_done_q <= 1'b1;
              st_q <= ST_IDLE;
            end
            else
            begin
              idx_q <= idx_q + 1'b1;
              bus_oe_q <= nxt[`LBC_SYM_ACT];
            end
          end
          else
            tmr_q <= tmr_q + 1'b1;
        end
        ST_BREAK:
        begin
          // Hold the line active for the break and release it; a cycle
          // later only the other drivers show on the bus, so look then
          if (tmr_q >= BREAK)
          begin
            rec_q <= !bus_act;
            st_q <= ST_WAIT;
          end
          else
          begin
            if (tmr_q == BREAK - 1)
              bus_oe_q <= 1'b0;
            tmr_q <= tmr_q + 1'b1;
          end
        end
        default:
        begin
          bus_oe_q <= 1'b0;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- verif/lbc_peer.sv ----
`timescale 1ns/1ps
module lbc_peer (
  input wire ref_clk, // Clock
  input wire dut_oe, // Device pulls
  input wire pull, // Peer pulls
  output wire bus_in // Wire level
);
  reg pull_q = 1'b0;
  // Peer moves its pull only at a clock edge
  always @(posedge ref_clk)
    pull_q <= pull;
  // Open-drain wire, the active level wins
  assign bus_in = !(dut_oe || pull_q);
endmodule

// ---- verif/lbc_chk.sv ----
`timescale 1ns/1ps
module lbc_chk #(parameter DESTROY = 50) (
  input wire ref_clk,
  input wire rst_n,
  input wire mm_en,
  input wire bus_in,
  input wire bus_out_q,
  input wire bus_oe_q,
  input wire busy_q,
  input wire tx_done_q,
  input wire coll_q,
  input wire coll_destroy_q
);
  reg [31:0] low_q;
  reg on_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Marks an attempt under way, from its first pull to its end
  always @(posedge ref_clk)
    if (!rst_n || !busy_q || coll_q)
      on_q <= 1'b0;
    else if (bus_oe_q)
      on_q <= 1'b1;
  // Counts active wire cycles while an attempt runs without collision
  always @(posedge ref_clk)
    if (!rst_n || bus_in || !busy_q || coll_q || !on_q)
      low_q <= 32'h0;
    else
      low_q <= low_q + 32'h1;
  // Break held with the collision flag
  sequence s_break;
    (coll_q && bus_oe_q) [*8];
  endsequence
  a_pin_low: assert property (bus_out_q == 1'b0)
    else $error("pin value not low");
  a_mode_gate: assert property ($rose(coll_q) |-> $past(mm_en))
    else $error("collision outside mode");
  a_plain_stop: assert property
    ($rose(coll_q) && !coll_destroy_q |-> !bus_oe_q)
    else $error("driving after collision");
  a_break_run: assert property
    ($rose(coll_destroy_q) |-> s_break)
    else $error("no break");
  a_clear_send: assert property
    ($fell(coll_q) |-> busy_q && !coll_destroy_q)
    else $error("flags cleared outside send");
  a_done_clean: assert property
    (tx_done_q |-> !bus_oe_q && !busy_q ##1 !tx_done_q)
    else $error("bad frame end");
  a_idle_quiet: assert property (!busy_q |-> !bus_oe_q)
    else $error("driven without frame");
  a_destroy_due: assert property (low_q <= DESTROY + 3)
    else $error("held wire not flagged");
endmodule
bind lbc_collision lbc_chk #(.DESTROY(DESTROY)) u_lbc_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .mm_en(mm_en), .bus_in(bus_in),
  .bus_out_q(bus_out_q), .bus_oe_q(bus_oe_q), .busy_q(busy_q),
  .tx_done_q(tx_done_q), .coll_q(coll_q),
  .coll_destroy_q(coll_destroy_q));

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg mm_en = 1'b0;
  reg sym_valid = 1'b0;
  reg [2:0] sym_data = 3'h0;
  reg pull = 1'b0;
  reg ce = 1'b1;
  wire sym_ready_q, bus_in, bus_out_q, bus_oe_q, busy_q;
  wire tx_done_q, coll_q, coll_destroy_q;
  integer error_cnt = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer n;
  // Shortened timing so that a run stays small
  localparam integer P_HMIN = 20;
  localparam integer P_DMAX = 48;
  localparam integer P_DST = 50;
  localparam integer P_STOP = 60;
  localparam integer P_BRK = 30;
  localparam integer P_PRIO = 40;
  localparam integer P_REC = 25;
  localparam integer P_HB = 22;
  localparam integer P_SETL = P_STOP + P_PRIO;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  lbc_collision #(.HALF_MIN(P_HMIN), .DBL_MAX(P_DMAX), .DESTROY(P_DST),
    .STOP(P_STOP), .BREAK(P_BRK), .PRIO(P_PRIO), .REC(P_REC),
    .HALF_BIT(P_HB)) u_lbc_collision (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .mm_en(mm_en),
    .sym_valid(sym_valid), .sym_ready_q(sym_ready_q),
    .sym_data(sym_data), .bus_in(bus_in), .bus_out_q(bus_out_q),
    .bus_oe_q(bus_oe_q), .busy_q(busy_q), .tx_done_q(tx_done_q),
    .coll_q(coll_q), .coll_destroy_q(coll_destroy_q));
  lbc_peer u_lbc_peer (.ref_clk(ref_clk), .dut_oe(bus_oe_q),
    .pull(pull), .bus_in(bus_in));
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string what, input logic exp, input logic got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s exp %b got %b", what, exp, got);
      end
    end
  endtask
  function logic pick(input integer w);
    case (w)
      0: pick = tx_done_q;
      1: pick = coll_q;
      2: pick = !coll_q;
      3: pick = bus_oe_q;
      default: pick = !bus_oe_q;
    endcase
  endfunction
  // Bounded wait at falling edges, cycles waited in n
  task wait_on(input integer w, input integer lim);
    begin
      n = 0;
      while (pick(w) !== 1'b1 && n < lim)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
    end
  endtask
  // Holds the word until the buffer has room
  task push(input [2:0] w);
    begin
      sym_data = w;
      sym_valid = 1'b1;
      while (sym_ready_q !== 1'b1)
        @(negedge ref_clk);
      @(negedge ref_clk);
    end
  endtask
  // Fills the buffer with sending off, then sends the frame
  task t_fill;
    begin
      push(3'h1);
      push(3'h2);
      push(3'h1);
      push(3'h4);
      sym_data = 3'h5;
      repeat (3) @(negedge ref_clk);
      chk("ready", 1'b0, sym_ready_q);
      sym_valid = 1'b0;
      chk("busy", 1'b0, busy_q);
      mm_en = 1'b1;
      wait_on(0, 600);
      chk("done", 1'b1, tx_done_q);
      chk("coll", 1'b0, coll_q);
      chk("ready", 1'b1, sym_ready_q);
      $display("fill test done");
    end
  endtask
  // Peer pulls the wire while the device sends idle
  task t_plain;
    begin
      push(3'h1);
      push(3'h2);
      push(3'h5);
      sym_valid = 1'b0;
      wait_on(3, 300);
      wait_on(4, 40);
      repeat (22) @(negedge ref_clk);
      pull = 1'b1;
      wait_on(1, 10);
      chk("kind", 1'b0, coll_destroy_q);
      chk("drive", 1'b0, bus_oe_q);
      repeat (22) @(negedge ref_clk);
      pull = 1'b0;
      wait_on(2, 300);
      chk("settle", 1'b1, n >= P_SETL && n <= P_SETL + 4);
      wait_on(0, 300);
      chk("resend", 1'b1, tx_done_q);
      $display("plain test done");
    end
  endtask
  // Wire held active past the limit, then recovery resend
  task t_destroy;
    begin
      push(3'h3);
      push(3'h4);
      sym_valid = 1'b0;
      wait_on(3, 300);
      pull = 1'b1;
      wait_on(1, 60);
      chk("hold len", 1'b1, n == P_DST + 1);
      chk("kind", 1'b1, coll_destroy_q);
      chk("break", 1'b1, bus_oe_q);
      pull = 1'b0;
      wait_on(4, 40);
      chk("break len", 1'b1, n == P_BRK);
      wait_on(2, 100);
      chk("recover", 1'b1, n >= P_REC && n <= P_REC + 3);
      wait_on(0, 100);
      chk("resend", 1'b1, tx_done_q);
      $display("destroy test done");
    end
  endtask
  // Peer stretches the device's active symbol to a period of P_DMAX
  task t_width;
    begin
      push(3'h3);
      push(3'h4);
      sym_valid = 1'b0;
      wait_on(3, 300);
      pull = 1'b1;
      repeat (P_DMAX - 1) @(negedge ref_clk);
      pull = 1'b0;
      wait_on(1, 10);
      chk("edge kind", 1'b1, coll_destroy_q);
      chk("edge break", 1'b1, bus_oe_q);
      wait_on(0, 200);
      chk("resend", 1'b1, tx_done_q);
      chk("cleared", 1'b0, coll_q);
      $display("width test done");
    end
  endtask
  // Clock enable low holds a symbol in place
  task t_freeze;
    begin
      push(3'h5);
      sym_valid = 1'b0;
      wait_on(3, 300);
      ce = 1'b0;
      repeat (P_HB + 3) @(negedge ref_clk);
      chk("frozen", 1'b1, bus_oe_q);
      ce = 1'b1;
      wait_on(0, 40);
      chk("resume", 1'b1, n == P_HB);
      $display("freeze test done");
    end
  endtask
  // Cuts a hang short
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  // Main sequence
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    t_fill;
    t_plain;
    t_destroy;
    t_width;
    t_freeze;
    close_out;
  end
endmodule
